// File: hdl/standby_mode_controller.sv
`timescale 1ns/10ps
// Operation
// - edge exit mode leaves stop state on rising edge of wake pin.
// - edge mode enters stop even when wake pin already high.
// - restart both oscillators for fast dual, low only for slow dual, high only for single (slow or fast).
// - warm-up interval from 2-bit select, everything halted meanwhile.
// - fast warm-up codes give 12.288/4.096/3.072/1.024 ms, doubled by stage select.
// - slow warm-up codes give 750/250/5.85/1.95 ms at 32.768 kHz.
// - after warm-up resume at instruction following the stop entry.
// - leaving stop clears timing generator prescaler and divider.
// - reset pin low during stop ends it with ordinary reset.
// - core doze halts cpu and watchdog, peripherals run, state held.
// - leaving core doze clears doze bit and returns to prior mode.
// - master enable 0: enabled source wakes, no service, continue after entry.
// - master enable 1: enabled source wakes and is serviced first.
// - watchdog interrupt just before doze entry is serviced, doze skipped.
// - reset pin low in any doze ends it, start in fast single run.
// - deep doze clocks only time base timer, state held.
// - deep doze exits on timebase source falling edge, freeze bit cleared.
// - deep doze exit sets timebase latch if timebase enabled.
// - stop state entered when software writes one to stop command bit with edge exit mode selected.
module standby_mode_controller (
   input wire logic mclk_i, // 40 MHz system clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire standby_pkg::ctrl_s ctrl_i, // software control bits
   input wire logic ctrl_wr_i, // one-cycle strobe: ctrl_i written
   input wire logic wake_pin_i, // external wake pin, asynchronous
   input wire logic reset_pin_n_i, // external reset pin, asynchronous, active low
   input wire logic div_tick_i, // divided basic clock tick (fast warm-up)
   input wire logic lf_tick_i, // low-clock tick (slow warm-up)
   input wire logic tbt_src_i, // timebase source clock, asynchronous
   input wire logic master_irq_enable_i, // master interrupt enable
   input wire logic irq_wake_i, // any enabled source pending (latch and enable)
   input wire logic wdt_irq_i, // watchdog interrupt pending
   input wire logic timebase_enable_i, // timebase enable bit
   output standby_pkg::gate_s gate_o, // oscillator and clock gating
   output standby_pkg::power_state_e state_o, // current power state
   output logic doze_bit_o, // core doze control bit readback
   output logic freeze_bit_o, // freeze bit readback
   output logic tg_clear_o, // pulse: clear prescaler and divider
   output logic resume_o, // pulse: resume after entering instruction
   output logic service_irq_o, // pulse: take the interrupt first
   output logic timebase_irq_o, // pulse: set timebase interrupt latch
   output logic pin_reset_o // pulse: ordinary reset request
);
   import standby_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] wake_sync_r, rst_sync_r, tbt_sync_r;
   logic wake_prev_r, tbt_prev_r;
   logic wake_rise, tbt_fall, rst_pin_low;

   // two stages for each asynchronous input
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wake_sync_r <= 2'h0;
         rst_sync_r <= 2'h3;
         tbt_sync_r <= 2'h0;
      end else begin
         wake_sync_r <= {wake_sync_r[0], wake_pin_i};
         rst_sync_r <= {rst_sync_r[0], reset_pin_n_i};
         tbt_sync_r <= {tbt_sync_r[0], tbt_src_i};
      end
   end

   // edge history reads only the second stage
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wake_prev_r <= 1'b0;
         tbt_prev_r <= 1'b0;
      end else begin
         wake_prev_r <= wake_sync_r[1];
         tbt_prev_r <= tbt_sync_r[1];
      end
   end

   assign wake_rise = wake_sync_r[1] & ~wake_prev_r;
   assign tbt_fall = ~tbt_sync_r[1] & tbt_prev_r;
   assign rst_pin_low = ~rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////
   // warm-up length lookup
   function automatic logic [18:0] warmup_len(input logic [1:0] sel, input logic slow,
                                              input logic dbl);
      logic [17:0] base;
      base = 18'h00000;
      if (slow) begin
         case (sel)
            2'h0: base = WU_SLOW_00;
            2'h1: base = WU_SLOW_01;
            2'h2: base = WU_SLOW_10;
            default: base = WU_SLOW_11;
         endcase
         warmup_len = {1'b0, base};
      end else begin
         case (sel)
            2'h0: base = WU_FAST_00;
            2'h1: base = WU_FAST_01;
            2'h2: base = WU_FAST_10;
            default: base = WU_FAST_11;
         endcase
         warmup_len = dbl ? {base, 1'b0} : {1'b0, base};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // latched mode settings
   power_state_e state_r;
   logic [1:0] wu_sel_r;
   logic wu_dbl_r, slow_r, dual_r;
   logic [18:0] wu_cnt_r;
   logic doze_r, freeze_r;

   // settings held from the last control write; stop holds them frozen
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wu_sel_r <= 2'h0;
         wu_dbl_r <= 1'b0;
         slow_r <= 1'b0;
         dual_r <= 1'b0;
      end else if (rst_pin_low) begin
         slow_r <= 1'b0;
         dual_r <= 1'b0;
      end else if (ctrl_wr_i && state_r == ST_RUN) begin
         wu_sel_r <= ctrl_i.warmup_select;
         wu_dbl_r <= ctrl_i.divider_stage_select;
         slow_r <= ctrl_i.slow_run;
         dual_r <= ctrl_i.dual_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power state machine
   logic enter_stop, enter_doze, enter_freeze, doze_wake;

   // stop entered regardless of the wake pin level in edge mode
   assign enter_stop = ctrl_wr_i && ctrl_i.stop_cmd &&
                       ctrl_i.exit_level_select == EXIT_EDGE_MODE;
   // a pending watchdog interrupt cancels doze entry
   assign enter_doze = ctrl_wr_i && ctrl_i.doze_cmd && !wdt_irq_i;
   assign enter_freeze = ctrl_wr_i && ctrl_i.timing_gen_freeze && !ctrl_i.doze_cmd;
   assign doze_wake = irq_wake_i;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i || rst_pin_low) begin
         state_r <= ST_RUN;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (enter_stop) begin
                  state_r <= ST_STOPPED;
               end else if (enter_doze) begin
                  state_r <= ST_CORE_DOZE;
               end else if (enter_freeze) begin
                  state_r <= ST_DEEP_DOZE;
               end
            end
            ST_STOPPED: begin
               if (wake_rise) begin
                  state_r <= ST_WARMUP;
               end
            end
            ST_WARMUP: begin
               if (wu_cnt_r == 19'h00000) begin
                  state_r <= ST_RUN;
               end
            end
            ST_CORE_DOZE: begin
               if (doze_wake) begin
                  state_r <= ST_RUN;
               end
            end
            ST_DEEP_DOZE: begin
               if (tbt_fall) begin
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // warm-up down-counter on divided ticks, or low-clock ticks in slow run, so it tracks the real oscillator
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wu_cnt_r <= 19'h00000;
      end else if (state_r == ST_STOPPED && wake_rise) begin
         wu_cnt_r <= warmup_len(wu_sel_r, slow_r, wu_dbl_r);
      end else if (state_r == ST_WARMUP && wu_cnt_r != 19'h00000 &&
                   (slow_r ? lf_tick_i : div_tick_i)) begin
         wu_cnt_r <= wu_cnt_r - 19'h00001;
      end
   end

   // control bits read back; hardware clears them on exit
   always_ff @(posedge mclk_i) begin
      if (!rstn_i || rst_pin_low) begin
         doze_r <= 1'b0;
         freeze_r <= 1'b0;
      end else begin
         if (state_r == ST_RUN && enter_doze) begin
            doze_r <= 1'b1;
         end else if (state_r == ST_CORE_DOZE && doze_wake) begin
            doze_r <= 1'b0;
         end
         if (state_r == ST_RUN && enter_freeze) begin
            freeze_r <= 1'b1;
         end else if (state_r == ST_DEEP_DOZE && tbt_fall) begin
            freeze_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event pulses
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         tg_clear_o <= 1'b0;
         resume_o <= 1'b0;
         service_irq_o <= 1'b0;
         timebase_irq_o <= 1'b0;
         pin_reset_o <= 1'b0;
      end else begin
         tg_clear_o <= state_r == ST_STOPPED && wake_rise;
         resume_o <= (state_r == ST_WARMUP && wu_cnt_r == 19'h00000) ||
                     (state_r == ST_CORE_DOZE && doze_wake) ||
                     (state_r == ST_DEEP_DOZE && tbt_fall);
         service_irq_o <= state_r == ST_CORE_DOZE && doze_wake &&
                          master_irq_enable_i;
         timebase_irq_o <= state_r == ST_DEEP_DOZE && tbt_fall &&
                           timebase_enable_i;
         pin_reset_o <= rst_pin_low && state_r != ST_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock gating and oscillator enables
   always_comb begin
      gate_o.hf_osc_en = 1'b1;
      gate_o.lf_osc_en = dual_r;
      gate_o.cpu_run = state_r == ST_RUN;
      gate_o.wdt_run = state_r == ST_RUN;
      gate_o.periph_clk_en = state_r == ST_RUN || state_r == ST_CORE_DOZE;
      gate_o.tbt_clk_en = state_r != ST_STOPPED && state_r != ST_WARMUP;
      if (state_r == ST_STOPPED) begin
         gate_o.hf_osc_en = 1'b0;
         gate_o.lf_osc_en = 1'b0;
      end else if (dual_r) begin
         gate_o.hf_osc_en = !slow_r;
         gate_o.lf_osc_en = 1'b1;
      end else begin
         gate_o.hf_osc_en = 1'b1;
         gate_o.lf_osc_en = 1'b0;
      end
   end

   assign state_o = state_r;
   assign doze_bit_o = doze_r;
   assign freeze_bit_o = freeze_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_stop_edge_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED && wake_rise && !rst_pin_low |=> state_r == ST_WARMUP)
      else $error("stop not left on wake edge");
   a_stop_entry_high: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_RUN && enter_stop && !rst_pin_low |=> state_r == ST_STOPPED)
      else $error("stop entry refused");
   a_tg_clear_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED && wake_rise |=> tg_clear_o)
      else $error("timing generator not cleared");
   a_warmup_halt: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP |-> !gate_o.cpu_run && !gate_o.periph_clk_en)
      else $error("logic ran during warm-up");
   a_warmup_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED && wake_rise && !slow_r && !wu_dbl_r && wu_sel_r == 2'h3
      |=> wu_cnt_r == {1'b0, WU_FAST_11})
      else $error("wrong fast warm-up length");
   a_doze_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_CORE_DOZE && doze_wake && !rst_pin_low |=> !doze_r && state_r == ST_RUN)
      else $error("doze bit not cleared on wake");
   a_irq_service: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_CORE_DOZE && doze_wake |=> service_irq_o == $past(master_irq_enable_i))
      else $error("service decision wrong");
   a_wdt_blocks: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_RUN && wdt_irq_i && ctrl_wr_i && ctrl_i.doze_cmd
      |=> state_r != ST_CORE_DOZE)
      else $error("doze entered with watchdog pending");
   a_reset_pin: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rst_pin_low |=> state_r == ST_RUN && !slow_r && !dual_r)
      else $error("reset pin did not end mode");
   a_deep_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_DEEP_DOZE && tbt_fall && !rst_pin_low
      |=> !freeze_r && timebase_irq_o == $past(timebase_enable_i))
      else $error("deep doze exit wrong");

   // waiting, gating and counting checks
   a_stop_osc_off: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED |-> !gate_o.hf_osc_en && !gate_o.lf_osc_en)
      else $error("oscillator left running in stop");
   a_osc_restart: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP
      |-> gate_o.hf_osc_en == !(dual_r && slow_r) && gate_o.lf_osc_en == dual_r)
      else $error("wrong oscillators restarted");
   a_warmup_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP && wu_cnt_r != 19'h00000 && !rst_pin_low
      |=> state_r == ST_WARMUP)
      else $error("warm-up ended early");
   a_warmup_tick: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP && wu_cnt_r != 19'h00000 && (slow_r ? lf_tick_i : div_tick_i)
      |=> wu_cnt_r == $past(wu_cnt_r) - 19'h00001)
      else $error("warm-up count missed a tick");
   a_warmup_still: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP && !(slow_r ? lf_tick_i : div_tick_i) |=> $stable(wu_cnt_r))
      else $error("warm-up counted without a tick");
   a_warmup_resume: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_WARMUP && wu_cnt_r == 19'h00000 && !rst_pin_low
      |=> state_r == ST_RUN && resume_o)
      else $error("no resume after warm-up");
   a_slow_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED && wake_rise && slow_r && wu_sel_r == 2'h2
      |=> wu_cnt_r == {1'b0, WU_SLOW_10})
      else $error("wrong slow warm-up length");
   a_dbl_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_STOPPED && wake_rise && !slow_r && wu_dbl_r && wu_sel_r == 2'h3
      |=> wu_cnt_r == {WU_FAST_11, 1'b0})
      else $error("doubled warm-up length wrong");
   a_core_halt: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_CORE_DOZE
      |-> !gate_o.cpu_run && !gate_o.wdt_run && gate_o.periph_clk_en)
      else $error("core doze gating wrong");
   a_core_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_CORE_DOZE && !doze_wake && !rst_pin_low
      |=> state_r == ST_CORE_DOZE && doze_r)
      else $error("core doze left without a source");
   a_deep_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_DEEP_DOZE
      |-> !gate_o.periph_clk_en && gate_o.tbt_clk_en && !gate_o.cpu_run)
      else $error("deep doze gating wrong");
   a_deep_wait: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_DEEP_DOZE && !tbt_fall && !rst_pin_low
      |=> state_r == ST_DEEP_DOZE && freeze_r)
      else $error("deep doze left without an edge");
   a_deep_resume: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      state_r == ST_DEEP_DOZE && tbt_fall && !rst_pin_low |=> state_r == ST_RUN && resume_o)
      else $error("no resume after deep doze");
   a_pin_reset_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rst_pin_low && state_r != ST_RUN |=> pin_reset_o)
      else $error("reset pin gave no reset request");
endmodule

// File: hdl/standby_pkg.sv
package standby_pkg;
   // warm-up lengths in divided-clock ticks, fast return (x2 when divider stage select set)
   localparam logic [17:0] WU_FAST_00 = 18'h30000;
   localparam logic [17:0] WU_FAST_01 = 18'h10000;
   localparam logic [17:0] WU_FAST_10 = 18'h0C000;
   localparam logic [17:0] WU_FAST_11 = 18'h04000;
   // warm-up lengths in low-clock ticks, slow return
   localparam logic [17:0] WU_SLOW_00 = 18'h06000;
   localparam logic [17:0] WU_SLOW_01 = 18'h02000;
   localparam logic [17:0] WU_SLOW_10 = 18'h000C0;
   localparam logic [17:0] WU_SLOW_11 = 18'h00040;
   localparam logic EXIT_EDGE_MODE = 1'b0;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_STOPPED,
      ST_WARMUP,
      ST_CORE_DOZE,
      ST_DEEP_DOZE
   } power_state_e;

   // software control bits
   typedef struct packed {
      logic stop_cmd;
      logic exit_level_select;
      logic [1:0] warmup_select;
      logic divider_stage_select;
      logic doze_cmd;
      logic timing_gen_freeze;
      logic dual_clock;
      logic slow_run;
   } ctrl_s;

   // oscillator and clock gating outputs
   typedef struct packed {
      logic hf_osc_en;
      logic lf_osc_en;
      logic cpu_run;
      logic wdt_run;
      logic periph_clk_en;
      logic tbt_clk_en;
   } gate_s;
endpackage

// File: testbench/standby_pin_model.sv
`timescale 1ns/10ps
// far side of the block: wake pin, reset pin and timebase source clock
module standby_pin_model (
   input wire logic mclk_i, // system clock, only paces the pin changes
   output logic wake_pin_o, // external wake pin level
   output logic reset_pin_n_o, // external reset pin, active low
   output logic tbt_src_o // timebase source clock
);
   // idle levels; the key wake inputs are not modelled, so they stay disabled
   initial begin
      wake_pin_o = 1'b0;
      reset_pin_n_o = 1'b1;
      tbt_src_o = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pins move just after an edge; the block synchronises them anyway
   task automatic set_wake(input logic v, input int hold);
      @(posedge mclk_i);
      #1;
      wake_pin_o = v;
      repeat (hold) @(posedge mclk_i);
      #1;
   endtask
   // reset held low long enough to pass the synchroniser
   task automatic pulse_reset(input int hold);
      @(posedge mclk_i);
      #1;
      reset_pin_n_o = 1'b0;
      repeat (hold) @(posedge mclk_i);
      #1;
      reset_pin_n_o = 1'b1;
   endtask
   // one source clock period, falling first; stands still outside it
   task automatic tbt_fall(input int hold);
      @(posedge mclk_i);
      #1;
      tbt_src_o = 1'b0;
      repeat (hold) @(posedge mclk_i);
      #1;
      tbt_src_o = 1'b1;
   endtask
endmodule

// File: testbench/test_standby_mode_controller.sv
`timescale 1ns/10ps
module test_standby_mode_controller;
   import standby_pkg::*;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   ctrl_s ctrl_i = '0;
   logic ctrl_wr_i = 1'b0;
   logic div_tick_i = 1'b0;
   logic lf_tick_i = 1'b0;
   logic master_irq_enable_i = 1'b0;
   logic irq_wake_i = 1'b0;
   logic wdt_irq_i = 1'b0;
   logic timebase_enable_i = 1'b0;
   logic wake_pin, reset_pin_n, tbt_src;
   gate_s gate_o;
   power_state_e state_o;
   logic doze_bit_o, freeze_bit_o, tg_clear_o, resume_o, service_irq_o, timebase_irq_o;
   logic pin_reset_o;
   int num_errors = 0;
   int comparisons = 0;
   // 40 MHz system clock
   always #12.5 mclk_i = ~mclk_i;
   standby_mode_controller dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ctrl_i(ctrl_i),
      .ctrl_wr_i(ctrl_wr_i), .wake_pin_i(wake_pin), .reset_pin_n_i(reset_pin_n),
      .div_tick_i(div_tick_i), .lf_tick_i(lf_tick_i), .tbt_src_i(tbt_src),
      .master_irq_enable_i(master_irq_enable_i), .irq_wake_i(irq_wake_i),
      .wdt_irq_i(wdt_irq_i), .timebase_enable_i(timebase_enable_i), .gate_o(gate_o),
      .state_o(state_o), .doze_bit_o(doze_bit_o), .freeze_bit_o(freeze_bit_o),
      .tg_clear_o(tg_clear_o), .resume_o(resume_o), .service_irq_o(service_irq_o),
      .timebase_irq_o(timebase_irq_o), .pin_reset_o(pin_reset_o));
   standby_pin_model pins (.mclk_i(mclk_i), .wake_pin_o(wake_pin),
      .reset_pin_n_o(reset_pin_n), .tbt_src_o(tbt_src));
   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers; inputs change and outputs are read 1 ns after the edge
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic write_ctrl(input ctrl_s c);
      ctrl_i = c;
      ctrl_wr_i = 1'b1;
      cyc(1);
      ctrl_wr_i = 1'b0;
   endtask
   // bounded wait; pulses that go with a state change are read in the same cycle
   task automatic wait_state(input power_state_e s, input int lim);
      for (int i = 0; i < lim && state_o !== s; i++) cyc(1);
      check(state_o, s);
   endtask
   task automatic tick(input logic slow, input int n);
      lf_tick_i = slow;
      div_tick_i = ~slow;
      cyc(n);
      lf_tick_i = 1'b0;
      div_tick_i = 1'b0;
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // stop entry with wake already high, edge exit, warm-up one tick short, then resume
   task automatic t_stop(input logic dual, slow, input logic [1:0] code, input logic dbl,
                         input int n, input logic [1:0] osc);
      ctrl_s c;
      c = '0;
      c.stop_cmd = 1'b1;
      c.warmup_select = code;
      c.divider_stage_select = dbl;
      c.dual_clock = dual;
      c.slow_run = slow;
      pins.set_wake(1'b1, 4);
      write_ctrl(c);
      check(state_o, ST_STOPPED);
      cyc(6);
      check(state_o, ST_STOPPED);
      pins.set_wake(1'b0, 4);
      check(state_o, ST_STOPPED);
      pins.set_wake(1'b1, 0);
      wait_state(ST_WARMUP, 8);
      check(tg_clear_o, 1'b1);
      check({gate_o.hf_osc_en, gate_o.lf_osc_en}, osc);
      check({gate_o.cpu_run, gate_o.wdt_run, gate_o.periph_clk_en}, 3'h0);
      tick(slow, n - 1);
      cyc(3);
      check(state_o, ST_WARMUP);
      tick(slow, 1);
      wait_state(ST_RUN, 3);
      check({resume_o, gate_o.cpu_run}, 2'h3);
      $display("done: stop exit code %0d", code);
   endtask
   // reset pin ends a stopped or dozing state; the run restarts fast single
   task automatic t_pin_reset(input ctrl_s c, input power_state_e s);
      write_ctrl(c);
      check(state_o, s);
      fork
         pins.pulse_reset(6);
         wait_state(ST_RUN, 10);
      join_any
      check({pin_reset_o, gate_o.hf_osc_en, gate_o.lf_osc_en}, 3'h6);
      cyc(8);
      $display("done: reset pin from state %0d", s);
   endtask
   // core doze, woken by an enabled source; m decides whether it is serviced
   task automatic t_core_doze(input logic m);
      master_irq_enable_i = m; // cleared first when m is 0
      cyc(1);
      write_ctrl(ctrl_s'(9'h008)); // doze only, freeze stays 0
      check({state_o, doze_bit_o}, {ST_CORE_DOZE, 1'b1});
      check({gate_o.cpu_run, gate_o.wdt_run, gate_o.periph_clk_en}, 3'h1);
      cyc(3);
      check(state_o, ST_CORE_DOZE);
      irq_wake_i = 1'b1;
      cyc(1);
      irq_wake_i = 1'b0; // latch cleared by software
      check({state_o, doze_bit_o, resume_o}, {ST_RUN, 2'h1});
      check(service_irq_o, m);
      wdt_irq_i = 1'b1;
      write_ctrl(ctrl_s'(9'h008));
      check({state_o, doze_bit_o}, {ST_RUN, 1'b0});
      wdt_irq_i = 1'b0;
      $display("done: core doze, master enable %0d", m);
   endtask
   // deep doze ends on the timebase source falling edge
   task automatic t_deep_doze(input logic en);
      timebase_enable_i = en;
      cyc(1);
      write_ctrl(ctrl_s'(9'h004)); // peripherals idle, doze bit 0
      check({state_o, freeze_bit_o}, {ST_DEEP_DOZE, 1'b1});
      check({gate_o.periph_clk_en, gate_o.tbt_clk_en, gate_o.cpu_run}, 3'h2);
      fork
         pins.tbt_fall(4);
         wait_state(ST_RUN, 10);
      join_any
      check({freeze_bit_o, resume_o}, 2'h1);
      check(timebase_irq_o, en);
      cyc(6);
      $display("done: deep doze, timebase enable %0d", en);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge mclk_i);
      #1;
      rstn_i = 1'b1;
      cyc(3);
      check({state_o, gate_o.hf_osc_en, gate_o.lf_osc_en}, {ST_RUN, 2'h2});
      write_ctrl(ctrl_s'(9'h180));
      check(state_o, ST_RUN);
      t_stop(1'b0, 1'b0, 2'h3, 1'b0, int'(WU_FAST_11), 2'h2);
      t_stop(1'b1, 1'b0, 2'h3, 1'b1, 2 * int'(WU_FAST_11), 2'h3);
      t_stop(1'b1, 1'b1, 2'h2, 1'b0, int'(WU_SLOW_10), 2'h1);
      t_stop(1'b1, 1'b1, 2'h3, 1'b0, int'(WU_SLOW_11), 2'h1);
      t_pin_reset(ctrl_s'(9'h100), ST_STOPPED);
      t_pin_reset(ctrl_s'(9'h008), ST_CORE_DOZE);
      t_pin_reset(ctrl_s'(9'h004), ST_DEEP_DOZE);
      for (int m = 0; m < 2; m++) t_core_doze(m[0]);
      for (int e = 0; e < 2; e++) t_deep_doze(e[0]);
      stop_test();
   end
   // watchdog sized well above the roughly 50000 cycles the tests need
   initial begin
      repeat (90000) @(posedge mclk_i);
      num_errors++;
      stop_test();
   end
endmodule
